// [core/cid_decades.sv]
`timescale 1ns/1ns
module cid_decades
	import cid_pkg::*;
(
	input wire logic clock,            // System clock.
	input wire logic rst_n,            // Synchronous reset, active low.
	cid_cnt_if.counter bus             // Counter control and count.
);

	typedef struct packed {
		logic [CNT_W-1:0] bcd;
	} cid_cnt_state_t;

	cid_cnt_state_t r;
	cid_cnt_state_t next_r;
	logic [DECADES:0]  carry;
	logic [CNT_W-1:0]  adv;

	assign carry[0] = bus.inc;

	// Each decade advances on its carry and passes a carry when it wraps.
	genvar k;
	generate
		for (k = 0; k < DECADES; k++) begin : g_dec
			logic [3:0] d;
			assign d = cid_code2dec(r.bcd[k*DIGIT_W +: DIGIT_W]);
			assign carry[k+1] = carry[k] && (d >= DIGIT_LAST);
			assign adv[k*DIGIT_W +: DIGIT_W] = !carry[k] ? r.bcd[k*DIGIT_W +: DIGIT_W] :
				(d >= DIGIT_LAST) ? DIGIT_ZERO : cid_dec2code(d + 4'h1);
		end
	endgenerate

	always_comb begin
		next_r = r;
		if (bus.clear) begin
			next_r.bcd = '0;
		end else if (bus.preset_stb) begin
			next_r.bcd = r.bcd | bus.preset_bits;
		end else begin
			next_r.bcd = adv;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign bus.bcd = r.bcd;

endmodule

// [core/cid_decimal.sv]
`timescale 1ns/1ns
module cid_decimal
	import cid_pkg::*;
(
	cid_dp_if.logic_side dp           // Switch settings in, decimal controls out.
);

	always_comb begin
		int  f;
		logic ok;
		logic mil;
		logic timed;
		logic manual;
		logic freq_man;
		logic incomplete;
		f = 0;
		ok = 1'b0;
		mil = 1'b0;
		incomplete = 1'b0;
		timed = (dp.per == PER_10MS) || (dp.per == PER_100MS) || (dp.per == PER_1S);
		manual = (dp.per == PER_START) || (dp.per == PER_STOP);
		freq_man = (dp.func == FN_FREQ) && manual;
		if ((dp.func == FN_FREQ) && timed) begin
			f = FRAC_BASE_FREQ + int'(dp.per);
			ok = 1'b1;
		end else if ((dp.func == FN_VOLT) && timed && (dp.rng <= RNG_1000)) begin
			f = FRAC_BASE_VOLT - int'(dp.rng) + int'(dp.per);
			if (f >= MILLI_LIMIT) begin
				f = f - MILLI_FOLD;
				mil = 1'b1;
			end
			if (dp.gain) begin
				if (mil) begin
					f = f + 1;
				end else if (f + 1 >= GAIN_MILLI_LIMIT) begin
					f = f + 1 - MILLI_FOLD - 1;
					mil = 1'b1;
				end else begin
					f = f + 1;
				end
			end
			ok = 1'b1;
		end
		ok = ok && (f >= 0) && (f < NPOS);
		incomplete = !ok;
		for (int i = 0; i < NPOS; i++) begin
			dp.lines[i] = ok && !freq_man && (f == i);
		end
		dp.blank = incomplete || freq_man;
		dp.r1000 = incomplete && !freq_man;
		dp.milli = ok && mil && !freq_man;
	end

endmodule

// [core/cid_if.sv]
`timescale 1ns/1ns
interface cid_cnt_if;
	import cid_pkg::*;
	logic             clear;
	logic             preset_stb;
	logic [CNT_W-1:0] preset_bits;
	logic             inc;
	logic [CNT_W-1:0] bcd;
	modport ctrl    (output clear, output preset_stb, output preset_bits, output inc, input bcd);
	modport counter (input clear, input preset_stb, input preset_bits, input inc, output bcd);
endinterface

interface cid_dp_if;
	logic [1:0]       func;
	logic [2:0]       rng;
	logic [2:0]       per;
	logic             gain;
	logic [4:0]       lines;
	logic             blank;
	logic             r1000;
	logic             milli;
	modport ctrl  (output func, output rng, output per, output gain,
		input lines, input blank, input r1000, input milli);
	modport logic_side (input func, input rng, input per, input gain,
		output lines, output blank, output r1000, output milli);
endinterface

// [core/cid_pkg.sv]
// Summary of operation
// - Reset pulse clears every decade to zero.
// - Preset pulse sets chosen 1-2-2'-4 bits only.
// - Volt function forwards converter pulses to units.
// - Frequency function forwards conditioned input pulses.
// - Pulses count only while counter gate open.
// - Manual START sets gate to measurement enable.
// - Manual STOP sets gate to measurement inhibit.
// - Decimal from function, range and sample period.
// - Frequency period selects one of three positions.
// - At most one decimal position line asserted.
// - No position line means incomplete program indication.
// - Incomplete, not freq-manual: blank and top range.
// - Freq-manual blanks decimals without top range.
// - Period picks 100, 10 or 1 Hz time base.
// - Selected time-base rising edge times the gate.
// - Times-ten gain shifts decimal, maybe lights milli.
// - 1 V, 0.01 s, x1 gives fourth line.
// - 1 V, 0.01 s, x10 gives second line, milli.
// - 1 V, 1 s, x10 gives fifth line.
package cid_pkg;

	localparam int DECADES = 6;
	localparam int DIGIT_W = 4;
	localparam int CNT_W   = DECADES * DIGIT_W;
	localparam int NPOS    = 5;

	// Bit positions inside one decade, weighted 1, 2, 2' and 4.
	localparam int BIT_W1  = 0;
	localparam int BIT_W2  = 1;
	localparam int BIT_W2P = 2;
	localparam int BIT_W4  = 3;
	localparam logic [3:0] DIGIT_LAST = 4'h9;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;

	localparam logic [1:0] FN_VOLT = 2'h1;
	localparam logic [1:0] FN_FREQ = 2'h2;

	localparam logic [2:0] RNG_0P1  = 3'h0;
	localparam logic [2:0] RNG_1000 = 3'h4;

	localparam logic [2:0] PER_10MS  = 3'h0;
	localparam logic [2:0] PER_100MS = 3'h1;
	localparam logic [2:0] PER_1S    = 3'h2;
	localparam logic [2:0] PER_START = 3'h3;
	localparam logic [2:0] PER_STOP  = 3'h4;

	// Fraction-digit arithmetic for decimal placement.
	localparam int FRAC_BASE_VOLT  = 4;
	localparam int FRAC_BASE_FREQ  = 1;
	localparam int MILLI_LIMIT     = 5;
	localparam int GAIN_MILLI_LIMIT = 4;
	localparam int MILLI_FOLD      = 2;

	// Synchronised pin vector layout.
	localparam int PIN_RESET  = 0;
	localparam int PIN_PRESET = 1;
	localparam int PIN_VFC    = 2;
	localparam int PIN_FREQ   = 3;
	localparam int PIN_GAIN   = 4;
	localparam int PIN_FN_LO  = 5;
	localparam int PIN_RNG_LO = 7;
	localparam int PIN_PER_LO = 10;
	localparam int PIN_W      = 13;
	localparam int EDGE_W     = 4;

	// Time base.
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TB_100HZ_NS    = 10_000_000;
	localparam int TB_DIV_DEFAULT = TB_100HZ_NS / CLK_PERIOD_NS;
	localparam int PRESCALE_W     = 20;

	function automatic logic [3:0] cid_code2dec(input logic [3:0] c);
		logic [3:0] s;
		s = 4'h0;
		if (c[BIT_W1]) s = s + 4'h1;
		if (c[BIT_W2]) s = s + 4'h2;
		if (c[BIT_W2P]) s = s + 4'h2;
		if (c[BIT_W4]) s = s + 4'h4;
		return s;
	endfunction

	function automatic logic [3:0] cid_dec2code(input logic [3:0] d);
		logic [3:0] c;
		c = 4'h0;
		unique case (d)
			4'h4: c = 4'h8;
			4'h5: c = 4'h9;
			4'h6: c = 4'ha;
			4'h7: c = 4'hb;
			4'h8: c = 4'he;
			4'h9: c = 4'hf;
			default: c = d;
		endcase
		return c;
	endfunction

endpackage

// [core/cid_top.sv]
`timescale 1ns/1ns
module cid_top
	import cid_pkg::*;
#(
	parameter int TB_DIV = TB_DIV_DEFAULT   // Clock cycles per 100 Hz time-base tick.
)(
	input  wire logic             clock,                   // 100 MHz system clock.
	input  wire logic             rst_n,                   // Synchronous reset, active low.
	input  wire logic             counter_reset_pin,       // Counter reset pulse, high.
	input  wire logic             preset_pin,              // Preset strobe, high.
	input  wire logic [CNT_W-1:0] preset_bits,             // Bits to set per decade.
	input  wire logic             vfc_pulse,               // Converter pulse train.
	input  wire logic             freq_pulse,              // Conditioned input pulses.
	input  wire logic [1:0]       func_sel,                // Function switch.
	input  wire logic [2:0]       range_sel,               // Voltage range switch.
	input  wire logic [2:0]       period_sel,              // Sample period switch.
	input  wire logic             gain_times_ten_line,     // Amplifier at x10 gain.
	output logic      [CNT_W-1:0] count_bcd,               // Six decades of count.
	output logic                  counter_gate_flipflop,   // High while counting.
	output logic                  timebase_event,          // Selected time-base edge.
	output logic      [NPOS-1:0]  decimal_position_lines,  // One-hot decimal place.
	output logic                  decimal_blank_line,      // Blanks all decimals.
	output logic                  range_1000_cmd,          // Forces top attenuator range.
	output logic                  milli_indicator          // Lights the milli legend.
);

	typedef struct packed {
		logic [PIN_W-1:0]      s1;
		logic [PIN_W-1:0]      s2;
		logic [EDGE_W-1:0]     s3;
		logic [CNT_W-1:0]      pre1;
		logic [CNT_W-1:0]      pre2;
		logic [PRESCALE_W-1:0] prescale;
		logic [3:0]            div10;
		logic [3:0]            div1;
		logic                  gate;
		logic                  tb_event;
		logic                  cnt_clear;
		logic                  cnt_preset;
		logic                  cnt_inc;
		logic [NPOS-1:0]       lines;
		logic                  blank;
		logic                  r1000;
		logic                  milli;
	} cid_state_t;

	localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(TB_DIV - 1);

	cid_state_t r;
	cid_state_t next_r;
	logic [PIN_W-1:0] pins;

	cid_cnt_if cnt ();
	cid_dp_if  dp ();

	////////////////////////////////////////////////////////////////////////////////

	// Every pin goes through two flip-flops before any logic reads it.
	assign pins = {period_sel, range_sel, func_sel, gain_times_ten_line,
		freq_pulse, vfc_pulse, preset_pin, counter_reset_pin};

	assign dp.func = r.s2[PIN_FN_LO +: 2];
	assign dp.rng  = r.s2[PIN_RNG_LO +: 3];
	assign dp.per  = r.s2[PIN_PER_LO +: 3];
	assign dp.gain = r.s2[PIN_GAIN];

	assign cnt.clear       = r.cnt_clear;
	assign cnt.preset_stb  = r.cnt_preset;
	assign cnt.preset_bits = r.pre2;
	assign cnt.inc         = r.cnt_inc;

	cid_decimal u_decimal (
		.dp (dp.logic_side)
	);

	cid_decades u_decades (
		.clock (clock),
		.rst_n (rst_n),
		.bus   (cnt.counter)
	);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [EDGE_W-1:0] rise;
		logic [2:0]        per;
		logic [1:0]        fn;
		logic              t100;
		logic              t10;
		logic              t1;
		logic              ev;
		logic              src;
		rise = '0;
		per = '0;
		fn = '0;
		t100 = 1'b0;
		t10 = 1'b0;
		t1 = 1'b0;
		ev = 1'b0;
		src = 1'b0;
		next_r = r;
		next_r.s1 = pins;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2[EDGE_W-1:0];
		next_r.pre1 = preset_bits;
		next_r.pre2 = r.pre1;
		rise = r.s2[EDGE_W-1:0] & ~r.s3;
		per = r.s2[PIN_PER_LO +: 3];
		fn = r.s2[PIN_FN_LO +: 2];

		// Decade time-base dividers give 100, 10 and 1 Hz ticks.
		t100 = (r.prescale == PRESCALE_LAST);
		t10 = t100 && (r.div10 == DIGIT_LAST);
		t1 = t10 && (r.div1 == DIGIT_LAST);
		next_r.prescale = t100 ? '0 : r.prescale + PRESCALE_W'(1);
		if (t100) begin
			next_r.div10 = (r.div10 == DIGIT_LAST) ? DIGIT_ZERO : r.div10 + 4'h1;
		end
		if (t10) begin
			next_r.div1 = (r.div1 == DIGIT_LAST) ? DIGIT_ZERO : r.div1 + 4'h1;
		end

		// Only the divider output matching the period reaches the gate.
		ev = ((per == PER_10MS) && t100) ||
			((per == PER_100MS) && t10) ||
			((per == PER_1S) && t1);
		next_r.tb_event = ev;

		// Gate control: reset closes, manual switch forces, time base toggles.
		if (rise[PIN_RESET]) begin
			next_r.gate = 1'b0;
		end else if (per == PER_START) begin
			next_r.gate = 1'b1;
		end else if (per == PER_STOP) begin
			next_r.gate = 1'b0;
		end else if (ev) begin
			next_r.gate = !r.gate;
		end else if (per > PER_STOP) begin
			next_r.gate = 1'b0;
		end

		// Counter input path chosen by function.
		if (fn == FN_VOLT) begin
			src = rise[PIN_VFC];
		end else if (fn == FN_FREQ) begin
			src = rise[PIN_FREQ];
		end else begin
			src = 1'b0;
		end
		next_r.cnt_inc = src && r.gate;
		next_r.cnt_clear = rise[PIN_RESET];
		next_r.cnt_preset = rise[PIN_PRESET];

		// Decimal controls are registered from the synchronised switches.
		next_r.lines = dp.lines;
		next_r.blank = dp.blank;
		next_r.r1000 = dp.r1000;
		next_r.milli = dp.milli;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign count_bcd              = cnt.bcd;
	assign counter_gate_flipflop  = r.gate;
	assign timebase_event         = r.tb_event;
	assign decimal_position_lines = r.lines;
	assign decimal_blank_line     = r.blank;
	assign range_1000_cmd         = r.r1000;
	assign milli_indicator        = r.milli;

endmodule

// [dv/cid_chk.sv]
`timescale 1ns/1ns
module cid_chk
	import cid_pkg::*;
#(
	parameter int TB_DIV = 10   // Cycles per 100 Hz tick.
)(
	input wire logic             clock,                  // Clock.
	input wire logic             rst_n,                  // Reset.
	input wire logic             counter_reset_pin,      // Clear pin.
	input wire logic             preset_pin,             // Preset pin.
	input wire logic [CNT_W-1:0] preset_bits,            // Preset bits.
	input wire logic             vfc_pulse,              // Converter pulses.
	input wire logic             freq_pulse,             // Input pulses.
	input wire logic [1:0]       func_sel,               // Function.
	input wire logic [2:0]       range_sel,              // Range.
	input wire logic [2:0]       period_sel,             // Period.
	input wire logic             gain_times_ten_line,    // Gain.
	input wire logic [CNT_W-1:0] count_bcd,              // Count.
	input wire logic             counter_gate_flipflop,  // Gate.
	input wire logic             timebase_event,         // Tick.
	input wire logic [NPOS-1:0]  decimal_position_lines, // Decimal place.
	input wire logic             decimal_blank_line,     // Blank.
	input wire logic             range_1000_cmd,         // Top range.
	input wire logic             milli_indicator         // Milli.
);
	logic [2:0]  up;
	logic [11:0] gap;
	logic [11:0] pst;
	logic [11:0] want;
	logic [2:0]  per_q;
	logic        ev;
	assign ev = counter_reset_pin | preset_pin;
	assign want = 12'((period_sel == PER_10MS ? 12'h1 : period_sel == PER_100MS ? 12'ha : 12'h64)
		* TB_DIV - 1);
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			up    <= 3'h0;
			gap   <= 12'h0;
			pst   <= 12'h0;
			per_q <= 3'h0;
		end else begin
			up    <= (up == 3'h7) ? up : up + 3'h1;
			gap   <= timebase_event ? 12'h0 : gap + 12'h1;
			pst   <= (period_sel != per_q) ? 12'h0 : (pst == 12'hfff) ? pst : pst + 12'h1;
			per_q <= period_sel;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_onehot;
		$onehot0(decimal_position_lines);
	endproperty
	a_onehot: assert property (p_onehot) else $error("decimal lines not one-hot");
	property p_incomplete;
		up == 3'h7 && decimal_position_lines == 5'h0 |-> decimal_blank_line;
	endproperty
	a_incomplete: assert property (p_incomplete) else $error("no place lit, no blank");
	property p_top_range;
		range_1000_cmd |-> decimal_blank_line && decimal_position_lines == 5'h0;
	endproperty
	a_top_range: assert property (p_top_range) else $error("top range while complete");
	property p_freq_man;
		(func_sel == FN_FREQ && period_sel == PER_STOP) [*3]
			|=> decimal_blank_line && !range_1000_cmd;
	endproperty
	a_freq_man: assert property (p_freq_man) else $error("manual freq blanking wrong");
	property p_start;
		(period_sel == PER_START && !counter_reset_pin) [*6] |-> counter_gate_flipflop;
	endproperty
	a_start: assert property (p_start) else $error("gate not open at start");
	property p_stop;
		(period_sel == PER_STOP) [*5] |-> !counter_gate_flipflop;
	endproperty
	a_stop: assert property (p_stop) else $error("gate not closed at stop");
	property p_hold;
		$changed(count_bcd) && !$past(counter_gate_flipflop) && !$past(counter_gate_flipflop, 2)
			|-> $past(ev, 3) || $past(ev, 4) || $past(ev, 5);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved with gate closed");
	property p_gap;
		timebase_event && period_sel < PER_START && pst > (want << 1) + 12'h10 |-> gap == want;
	endproperty
	a_gap: assert property (p_gap) else $error("time base spacing wrong");
	property p_evgate;
		$rose(timebase_event) && period_sel < PER_START && pst > 12'h8 && up == 3'h7
			|-> counter_gate_flipflop != $past(counter_gate_flipflop);
	endproperty
	a_evgate: assert property (p_evgate) else $error("gate did not follow tick");
	c_tick: cover property (timebase_event);
	c_milli: cover property (milli_indicator);
	c_top: cover property (range_1000_cmd);
endmodule

bind cid_top cid_chk #(.TB_DIV(TB_DIV)) u_chk (.clock(clock), .rst_n(rst_n),
	.counter_reset_pin(counter_reset_pin), .preset_pin(preset_pin), .preset_bits(preset_bits),
	.vfc_pulse(vfc_pulse), .freq_pulse(freq_pulse), .func_sel(func_sel), .range_sel(range_sel),
	.period_sel(period_sel), .gain_times_ten_line(gain_times_ten_line), .count_bcd(count_bcd),
	.counter_gate_flipflop(counter_gate_flipflop), .timebase_event(timebase_event),
	.decimal_position_lines(decimal_position_lines), .decimal_blank_line(decimal_blank_line),
	.range_1000_cmd(range_1000_cmd), .milli_indicator(milli_indicator));

// [dv/cid_panel.sv]
`timescale 1ns/1ns
module cid_panel (
	input  wire logic clock,      // System clock.
	output logic      vfc_pulse,  // Converter pulses.
	output logic      freq_pulse  // Conditioned input pulses.
);
	initial begin
		vfc_pulse  = 1'b0;
		freq_pulse = 1'b0;
	end
	// Each pulse stays high three cycles and low three so every edge is caught.
	task automatic burst(input int n, input logic use_freq);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			#1;
			if (use_freq)
				freq_pulse = 1'b1;
			else
				vfc_pulse = 1'b1;
			repeat (3) @(posedge clock);
			#1;
			vfc_pulse  = 1'b0;
			freq_pulse = 1'b0;
			repeat (2) @(posedge clock);
		end
	endtask
endmodule

// [dv/test_counter_input_decimal_logic.sv]
`timescale 1ns/1ns
module test_counter_input_decimal_logic
	import cid_pkg::*;
();
	logic             clock = 1'b0;
	logic             rst_n;
	logic             counter_reset_pin;
	logic             preset_pin;
	logic [CNT_W-1:0] preset_bits;
	logic             vfc_pulse;
	logic             freq_pulse;
	logic [1:0]       func_sel;
	logic [2:0]       range_sel;
	logic [2:0]       period_sel;
	logic             gain_times_ten_line;
	logic [CNT_W-1:0] count_bcd;
	logic             counter_gate_flipflop;
	logic             timebase_event;
	logic [NPOS-1:0]  decimal_position_lines;
	logic             decimal_blank_line;
	logic             range_1000_cmd;
	logic             milli_indicator;
	logic [16:0]      rows [12];
	logic [7:0]       dec_out;
	logic [23:0]      n_ev;
	int               n_fail = 0;
	int               n_checks = 0;

	always #5 clock = ~clock;

	cid_top #(.TB_DIV(10)) DUT (.clock(clock), .rst_n(rst_n),
		.counter_reset_pin(counter_reset_pin), .preset_pin(preset_pin), .preset_bits(preset_bits),
		.vfc_pulse(vfc_pulse), .freq_pulse(freq_pulse), .func_sel(func_sel), .range_sel(range_sel),
		.period_sel(period_sel), .gain_times_ten_line(gain_times_ten_line), .count_bcd(count_bcd),
		.counter_gate_flipflop(counter_gate_flipflop), .timebase_event(timebase_event),
		.decimal_position_lines(decimal_position_lines), .decimal_blank_line(decimal_blank_line),
		.range_1000_cmd(range_1000_cmd), .milli_indicator(milli_indicator));
	cid_panel u_panel (.clock(clock), .vfc_pulse(vfc_pulse), .freq_pulse(freq_pulse));

	assign dec_out = {decimal_position_lines, decimal_blank_line, range_1000_cmd, milli_indicator};

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [23:0] seen, input logic [23:0] want);
		n_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic pulse_pin(input logic is_preset);
		if (is_preset)
			preset_pin = 1'b1;
		else
			counter_reset_pin = 1'b1;
		tick(3);
		preset_pin        = 1'b0;
		counter_reset_pin = 1'b0;
		tick(6);
	endtask
	task automatic results;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#100000;
		n_fail++;
		results();
	end

	initial begin
		rows[0] = {FN_FREQ, RNG_0P1, PER_10MS, 1'h0, 5'h02, 3'h0};
		rows[1] = {FN_FREQ, RNG_0P1, PER_100MS, 1'h0, 5'h04, 3'h0};
		rows[2] = {FN_FREQ, RNG_0P1, PER_1S, 1'h0, 5'h08, 3'h0};
		rows[3] = {FN_VOLT, 3'h1, PER_10MS, 1'h0, 5'h08, 3'h0};
		rows[4] = {FN_VOLT, 3'h1, PER_10MS, 1'h1, 5'h02, 3'h1};
		rows[5] = {FN_VOLT, 3'h1, PER_1S, 1'h1, 5'h10, 3'h1};
		rows[6] = {FN_VOLT, RNG_1000, PER_10MS, 1'h0, 5'h01, 3'h0};
		rows[7] = {FN_VOLT, RNG_0P1, PER_1S, 1'h0, 5'h10, 3'h1};
		rows[8] = {FN_FREQ, RNG_0P1, PER_START, 1'h0, 5'h00, 3'h4};
		rows[9] = {2'h0, RNG_0P1, PER_10MS, 1'h0, 5'h00, 3'h6};
		rows[10] = {FN_VOLT, 3'h2, PER_100MS, 1'h0, 5'h08, 3'h0};
		rows[11] = {FN_VOLT, 3'h3, PER_1S, 1'h1, 5'h02, 3'h1};
		rst_n = 1'b0;
		counter_reset_pin = 1'b0;
		preset_pin = 1'b0;
		preset_bits = 24'h0;
		{func_sel, range_sel, period_sel, gain_times_ten_line} = {FN_VOLT, 3'h1, PER_STOP, 1'h0};
		tick(5);
		rst_n = 1'b1;
		for (int i = 0; i < 12; i++) begin
			{func_sel, range_sel, period_sel, gain_times_ten_line} = rows[i][16:8];
			tick(5);
			chk(dec_out, rows[i][7:0]);
		end
		func_sel = FN_VOLT;
		period_sel = PER_START;
		tick(6);
		chk(counter_gate_flipflop, 1'b1);
		u_panel.burst(3, 1'b0);
		u_panel.burst(2, 1'b1);
		tick(5);
		chk(count_bcd, 24'h3);
		func_sel = FN_FREQ;
		tick(5);
		u_panel.burst(8, 1'b1);
		tick(5);
		chk(count_bcd, 24'h11);
		period_sel = PER_STOP;
		tick(5);
		chk(counter_gate_flipflop, 1'b0);
		u_panel.burst(2, 1'b1);
		tick(5);
		chk(count_bcd, 24'h11);
		pulse_pin(1'b0);
		chk(count_bcd, 24'h0);
		preset_bits = 24'h0fe8a0;
		tick(4);
		pulse_pin(1'b1);
		chk(count_bcd, 24'h0fe8a0);
		preset_bits = 24'h000002;
		tick(4);
		pulse_pin(1'b1);
		chk(count_bcd, 24'h0fe8a2);
		for (int p = 0; p < 2; p++) begin
			period_sel = p ? PER_100MS : PER_10MS;
			tick(250);
			n_ev = 24'h0;
			repeat (200) begin
				tick(1);
				n_ev = n_ev + 24'(timebase_event);
			end
			chk(n_ev, p ? 24'h2 : 24'h14);
		end
		rst_n = 1'b0;
		tick(2);
		chk(count_bcd, 24'h0);
		chk({counter_gate_flipflop, decimal_position_lines, decimal_blank_line}, 24'h0);
		rst_n = 1'b1;
		tick(8);
		results();
	end
endmodule
